/* src/acr_pkg.sv */
package acr_pkg;

   // apb byte offsets
   localparam logic [7:0] ACR_OFF_SC1 = 8'h00;
   localparam logic [7:0] ACR_OFF_SC2 = 8'h04;
   localparam logic [7:0] ACR_OFF_RH = 8'h08;
   localparam logic [7:0] ACR_OFF_RL = 8'h0c;
   localparam logic [7:0] ACR_OFF_CVH = 8'h10;
   localparam logic [7:0] ACR_OFF_CVL = 8'h14;
   localparam logic [7:0] ACR_OFF_CFG = 8'h18;

   // first status/control fields
   localparam int ACR_SC1_CONVERSION_COMPLETE_FLAG = 7;
   localparam int ACR_SC1_IEN = 6;
   localparam int ACR_SC1_CONT = 5;
   localparam int ACR_SC1_CH_LSB = 0;
   localparam int ACR_CH_W = 5;
   localparam logic [4:0] ACR_CH_OFF = 5'h1f;

   // second status/control fields
   localparam int ACR_SC2_ACT = 7;
   localparam int ACR_SC2_TRG = 6;
   localparam int ACR_SC2_CMPE = 5;
   localparam int ACR_SC2_CMPGE = 4;

   // configuration fields
   localparam int ACR_CFG_LP = 7;
   localparam int ACR_CFG_DIV_LSB = 5;
   localparam int ACR_CFG_LSMP = 4;
   localparam int ACR_CFG_MODE_LSB = 2;
   localparam int ACR_CFG_CLK_LSB = 0;

   // field codes
   localparam logic [1:0] ACR_MODE_8 = 2'h0;
   localparam logic [1:0] ACR_MODE_10 = 2'h2;
   localparam logic [1:0] ACR_CLK_BUS = 2'h0;
   localparam logic [1:0] ACR_CLK_HALF = 2'h1;
   localparam logic [1:0] ACR_CLK_ALT = 2'h2;
   localparam logic [1:0] ACR_CLK_ASYNC = 2'h3;

   // reset values
   localparam logic [7:0] ACR_RST_SC1 = 8'h1f;
   localparam logic [7:0] ACR_RST_SC2 = 8'h00;
   localparam logic [7:0] ACR_RST_CV = 8'h00;
   localparam logic [7:0] ACR_RST_CFG = 8'h00;
   localparam logic [9:0] ACR_RST_RES = 10'h000;

   // settings handed to the analog converter
   typedef struct packed {
      logic [4:0] channel_select;
      logic low_power_config;
      logic long_sample_select;
      logic mode_ten_bit;
   } acr_conv_cfg_s;

   typedef enum logic [1:0] {
      ACR_IDLE = 2'b01,
      ACR_BUSY = 2'b10
   } acr_state_e;

endpackage

/* src/acr_clk_div.sv */
`timescale 1ns/1ps
module acr_clk_div
   import acr_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic src_tick,
   input wire logic [1:0] div_sel,
   output logic conv_tick
);

   logic [2:0] count;
   logic [2:0] wrap;
   logic at_wrap;

   // 00/01/10/11 give ratios 1/2/4/8
   assign wrap = 3'(({1'b0, 3'h1} << div_sel) - 4'h1);
   assign at_wrap = (count >= wrap);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= 3'h0;
      end else if (src_tick) begin
         count <= at_wrap ? 3'h0 : 3'(count + 3'h1);
      end
   end

   assign conv_tick = src_tick & at_wrap;

endmodule

/* src/acr_ctrl.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - active bit 7 sets at conversion start, clears on completion or abort
// - trigger bit 6: 0 starts on control-one write, 1 on hardware trigger
// - compare-enable bit 5 turns automatic compare on or off
// - direction bit 4: 0 less-than, 1 greater-or-equal
// - result-high holds top two bits; zero in 8-bit mode
// - results load at every completion unless compare on and false, or blocked in 10-bit mode
// - 10-bit: reading result-high blocks transfers until result-low read
// - results completing while blocked are discarded
// - 8-bit mode has no read interlock
// - mode change invalidates result registers until next conversion
// - result-low holds low eight bits, or whole 8-bit result
// - upper compare bits used only in 10-bit mode
// - low eight compare bits always compared
// - low-power bit 7 selects reduced-power converter setting
// - divider bits 6:5 divide input clock by 1, 2, 4, 8
// - sample-time bit 4 selects short or long sample
// - mode bits 3:2: 00 8-bit, 10 10-bit, others reserved
// - clock bits 1:0: bus, bus half, alternate, internal async
// - control-one write aborts, then with trigger bit 6 at 0 starts unless channel all ones
// - complete flag sets per compare; clears on control-one write or low read
module acr_ctrl
   import acr_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic hardware_trigger_input,
   input wire logic alternate_clock_input,
   input wire logic internal_async_clock,
   input wire logic conv_done,
   input wire logic [9:0] conv_data,
   output logic conv_start,
   output logic conv_abort,
   output logic conversion_clock,
   output acr_conv_cfg_s conv_cfg
);

   ////////////////////////////////////////////////////////////////////////
   // registers
   logic [7:0] sc1;
   logic conversion_complete_flag;
   logic trigger_select;
   logic compare_enable;
   logic compare_greater_equal;
   logic [7:0] cvh;
   logic [7:0] cvl;
   logic [7:0] cfg;
   logic [9:0] result;
   logic read_lock;
   logic mode_ten;
   acr_state_e state;
   acr_state_e next_state;

   ////////////////////////////////////////////////////////////////////////
   // apb decode
   logic setup;
   logic access;
   logic wr;
   logic rd;
   logic hit_sc1;
   logic hit_sc2;
   logic hit_rh;
   logic hit_rl;
   logic hit_cvh;
   logic hit_cvl;
   logic hit_cfg;
   logic mapped;
   logic [7:0] rd_mux;

   assign setup = psel & ~penable;
   assign access = psel & penable;
   assign hit_sc1 = (paddr == ACR_OFF_SC1);
   assign hit_sc2 = (paddr == ACR_OFF_SC2);
   assign hit_rh = (paddr == ACR_OFF_RH);
   assign hit_rl = (paddr == ACR_OFF_RL);
   assign hit_cvh = (paddr == ACR_OFF_CVH);
   assign hit_cvl = (paddr == ACR_OFF_CVL);
   assign hit_cfg = (paddr == ACR_OFF_CFG);
   assign mapped = hit_sc1 | hit_sc2 | hit_rh | hit_rl | hit_cvh | hit_cvl
                 | hit_cfg;
   assign wr = access & pwrite & mapped;
   assign rd = access & ~pwrite & mapped;
   assign pready = 1'b1;
   assign pslverr = access & ~mapped;

   // zero-wait slave: read data captured in the setup cycle
   assign rd_mux =
      hit_sc1 ? {conversion_complete_flag, sc1[6:0]} :
      hit_sc2 ? {state == ACR_BUSY, trigger_select, compare_enable,
                 compare_greater_equal, 4'h0} :
      hit_rh ? {6'h00, result[9:8]} :
      hit_rl ? result[7:0] :
      hit_cvh ? {6'h00, cvh[1:0]} :
      hit_cvl ? cvl :
      hit_cfg ? cfg : 8'h00;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup) begin
         prdata <= {24'h00_0000, rd_mux};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers, third stage feeds the edge detect only
   logic [2:0] trig_sync;
   logic [2:0] alt_sync;
   logic [2:0] async_sync;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trig_sync <= 3'h0;
         alt_sync <= 3'h0;
         async_sync <= 3'h0;
      end else begin
         trig_sync <= {trig_sync[1:0], hardware_trigger_input};
         alt_sync <= {alt_sync[1:0], alternate_clock_input};
         async_sync <= {async_sync[1:0], internal_async_clock};
      end
   end

   logic trig_edge;
   assign trig_edge = trig_sync[1] & ~trig_sync[2];

   ////////////////////////////////////////////////////////////////////////
   // conversion clock source and divider
   logic half_phase;
   logic src_tick;
   logic div_tick;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         half_phase <= 1'b0;
      end else begin
         half_phase <= ~half_phase;
      end
   end

   // clock source pick
   // slow pins are sampled, so alt and async must run well below pclk
   assign src_tick =
      (cfg[ACR_CFG_CLK_LSB +: 2] == ACR_CLK_BUS) ? 1'b1 :
      (cfg[ACR_CFG_CLK_LSB +: 2] == ACR_CLK_HALF) ? half_phase :
      (cfg[ACR_CFG_CLK_LSB +: 2] == ACR_CLK_ALT) ?
         (alt_sync[1] & ~alt_sync[2]) :
      (async_sync[1] & ~async_sync[2]);

   acr_clk_div u_div (
      .pclk(pclk),
      .presetn(presetn),
      .src_tick(src_tick),
      .div_sel(cfg[ACR_CFG_DIV_LSB +: 2]),
      .conv_tick(div_tick)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conversion_clock <= 1'b0;
      end else begin
         conversion_clock <= div_tick;
      end
   end

   assign conv_cfg.channel_select = sc1[ACR_SC1_CH_LSB +: ACR_CH_W];
   assign conv_cfg.low_power_config = cfg[ACR_CFG_LP];
   assign conv_cfg.long_sample_select = cfg[ACR_CFG_LSMP];
   assign conv_cfg.mode_ten_bit = mode_ten;

   ////////////////////////////////////////////////////////////////////////
   // triggering and sequencing
   logic sc1_wr;
   logic ch_off;
   logic new_cont;
   logic sw_start;
   logic hw_start;
   logic cont_start;
   logic start_now;

   // only code 10 is 10-bit; reserved codes act as 8-bit
   assign mode_ten = (cfg[ACR_CFG_MODE_LSB +: 2] == ACR_MODE_10);
   assign sc1_wr = wr & hit_sc1;
   assign ch_off = sc1_wr ? (pwdata[ACR_CH_W-1:0] == ACR_CH_OFF)
                          : (sc1[ACR_CH_W-1:0] == ACR_CH_OFF);
   assign new_cont = sc1_wr ? pwdata[ACR_SC1_CONT] : sc1[ACR_SC1_CONT];
   assign sw_start = sc1_wr & ~trigger_select;
   assign hw_start = trig_edge & trigger_select & (state == ACR_IDLE);
   assign cont_start = conv_done & (state == ACR_BUSY) & new_cont
                     & ~trigger_select;
   assign start_now = (sw_start | hw_start | cont_start) & ~ch_off;

   assign conv_abort = sc1_wr & (state == ACR_BUSY);
   assign conv_start = start_now;

   // active tracks start, completion and abort
   always_comb begin
      next_state = state;
      case (state)
         ACR_IDLE: begin
            if (start_now) begin
               next_state = ACR_BUSY;
            end
         end
         ACR_BUSY: begin
            if (start_now) begin
               next_state = ACR_BUSY;
            end else if (conv_done | sc1_wr) begin
               next_state = ACR_IDLE;
            end
         end
         default: begin
            next_state = ACR_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ACR_IDLE;
      end else begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // compare
   logic done_ok;
   logic [9:0] cv_full;
   logic [9:0] res_cmp;
   logic less;
   logic cmp_true;
   logic store_ok;

   // a completion racing an abort write belongs to the aborted run
   assign done_ok = conv_done & (state == ACR_BUSY) & ~sc1_wr;
   // upper bits only in 10-bit mode
   assign cv_full = {mode_ten ? cvh[1:0] : 2'h0, cvl};
   assign res_cmp = {mode_ten ? conv_data[9:8] : 2'h0, conv_data[7:0]};
   assign less = (res_cmp < cv_full);
   assign cmp_true = compare_greater_equal ? ~less : less;
   assign store_ok = done_ok & (~compare_enable | cmp_true);

   ////////////////////////////////////////////////////////////////////////
   // result registers and interlock
   logic mode_change;
   logic rh_read;
   logic rl_read;
   logic load_result;

   // mode field rewrite with a new value
   assign mode_change = wr & hit_cfg
      & (pwdata[ACR_CFG_MODE_LSB +: 2] != cfg[ACR_CFG_MODE_LSB +: 2]);
   assign rh_read = rd & hit_rh;
   assign rl_read = rd & hit_rl;
   // blocked completions are dropped in 10-bit only
   assign load_result = store_ok & ~(read_lock & mode_ten);

   // no write path into result or lock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result <= ACR_RST_RES;
      end else if (mode_change) begin
         result <= ACR_RST_RES;
      end else if (load_result) begin
         // high bits zero in 8-bit mode
         result <= {mode_ten ? conv_data[9:8] : 2'h0, conv_data[7:0]};
      end
   end

   // high read arms lock in 10-bit mode only, low read releases it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         read_lock <= 1'b0;
      end else if (mode_change | rl_read) begin
         read_lock <= 1'b0;
      end else if (rh_read & mode_ten) begin
         read_lock <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // completion flag, set wins over clear
   // flag set and clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conversion_complete_flag <= 1'b0;
      end else if (store_ok) begin
         conversion_complete_flag <= 1'b1;
      end else if (sc1_wr | rl_read) begin
         conversion_complete_flag <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // writable registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sc1 <= ACR_RST_SC1;
         trigger_select <= 1'b0;
         compare_enable <= 1'b0;
         compare_greater_equal <= 1'b0;
         cvh <= ACR_RST_CV;
         cvl <= ACR_RST_CV;
         cfg <= ACR_RST_CFG;
      end else if (wr) begin
         if (hit_sc1) begin
            sc1 <= {1'b0, pwdata[6:0]};
         end
         if (hit_sc2) begin
            // reserved low bits dropped, read as zero
            trigger_select <= pwdata[ACR_SC2_TRG];
            compare_enable <= pwdata[ACR_SC2_CMPE];
            compare_greater_equal <= pwdata[ACR_SC2_CMPGE];
         end
         if (hit_cvh) begin
            cvh <= {6'h00, pwdata[1:0]};
         end
         if (hit_cvl) begin
            cvl <= pwdata[7:0];
         end
         if (hit_cfg) begin
            cfg <= pwdata[7:0];
         end
      end
   end

endmodule

/* dv/acr_ctrl_checker.sv */
`timescale 1ns/1ps
module acr_ctrl_checker
   import acr_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic hardware_trigger_input,
   input wire logic alternate_clock_input,
   input wire logic internal_async_clock,
   input wire logic conv_done,
   input wire logic [9:0] conv_data,
   input wire logic conv_start,
   input wire logic conv_abort,
   input wire logic conversion_clock,
   input wire acr_conv_cfg_s conv_cfg
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic sc1_wr = psel && penable && pwrite && paddr == ACR_OFF_SC1;
   logic hw_mode;
   // trigger mode is shadowed here since it is not visible at the ports
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         hw_mode <= 1'b0;
      else if (psel && penable && pwrite && paddr == ACR_OFF_SC2)
         hw_mode <= pwdata[ACR_SC2_TRG];
   end
   //////////////////////////////
   sequence s_cfg_wr;
      psel && penable && pwrite && paddr == ACR_OFF_CFG;
   endsequence
   sequence s_rh_rd;
      psel && !penable && !pwrite && paddr == ACR_OFF_RH ##1 penable;
   endsequence
   a_abort_cause: assert property (conv_abort |-> sc1_wr)
      else $error("abort without control-one write");
   a_off_no_start: assert property (
      sc1_wr && pwdata[4:0] == ACR_CH_OFF |-> !conv_start)
      else $error("start with channel off");
   a_sw_start: assert property (
      !hw_mode && sc1_wr && pwdata[4:0] != ACR_CH_OFF |-> conv_start)
      else $error("software trigger gave no start");
   a_start_cause: assert property (conv_start |-> sc1_wr || conv_done ||
      $past(hardware_trigger_input, 2) || $past(hardware_trigger_input, 3)
      || $past(hardware_trigger_input, 4))
      else $error("start without cause");
   a_rh_eight_zero: assert property (
      (!conv_cfg.mode_ten_bit ##0 s_rh_rd) |-> prdata[1:0] == 2'h0)
      else $error("high result bits set in 8-bit mode");
   a_unmapped_err: assert property (
      psel && penable && paddr > ACR_OFF_CFG |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_cfg_follow: assert property (s_cfg_wr |=>
      conv_cfg.low_power_config == $past(pwdata[7]) &&
      conv_cfg.long_sample_select == $past(pwdata[4]) &&
      conv_cfg.mode_ten_bit == ($past(pwdata[3:2]) == ACR_MODE_10))
      else $error("converter settings do not follow configuration");
   a_chan_follow: assert property (
      sc1_wr |=> conv_cfg.channel_select == $past(pwdata[4:0]))
      else $error("channel does not follow control-one");
endmodule

/* dv/acr_conv_model.sv */
`timescale 1ns/1ps
module acr_conv_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic conv_start,
   input wire logic conv_abort,
   input wire logic [7:0] lat,
   input wire logic [9:0] next_value,
   output logic conv_done,
   output logic [9:0] conv_data
);
   int cnt;
   logic [9:0] last;
   // data is only valid with done; otherwise show the inverse of the last
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 0;
         conv_done <= 1'b0;
         conv_data <= 10'h000;
         last <= 10'h000;
      end else begin
         conv_done <= 1'b0;
         conv_data <= ~last;
         if (conv_start)
            cnt <= int'(lat);
         else if (conv_abort)
            cnt <= 0;
         else if (cnt == 1) begin
            cnt <= 0;
            conv_done <= 1'b1;
            conv_data <= next_value;
            last <= next_value;
         end else if (cnt > 1)
            cnt <= cnt - 1;
      end
   end
endmodule

/* dv/adc_control_compare_result_tb_top.sv */
`timescale 1ns/1ps
module adc_control_compare_result_tb_top import acr_pkg::*;;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic hardware_trigger_input = 0;
   logic alternate_clock_input = 0, internal_async_clock = 0;
   logic [7:0] paddr = 0, lat = 8'd12;
   logic [31:0] pwdata = 0, prdata, rdat;
   logic pready, pslverr, rerr, conv_done, conv_start, conv_abort;
   logic conversion_clock;
   logic [9:0] conv_data, mval = 0;
   acr_conv_cfg_s conv_cfg;
   int n_errors = 0, check_count = 0, cyc = 0, n_abort = 0;
   logic [7:0] ra [6] = '{ACR_OFF_SC2, ACR_OFF_RH, ACR_OFF_RL, ACR_OFF_CVH,
      ACR_OFF_CVL, ACR_OFF_CFG};
   always #2.5 pclk = ~pclk;
   always #7 alternate_clock_input = ~alternate_clock_input;
   always #11 internal_async_clock = ~internal_async_clock;
   // abort pulses counted mid-cycle, where the decode has settled
   always @(negedge pclk) n_abort += (conv_abort === 1'b1);
   acr_ctrl dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .hardware_trigger_input,
      .alternate_clock_input, .internal_async_clock, .conv_done, .conv_data,
      .conv_start, .conv_abort, .conversion_clock, .conv_cfg);
   acr_conv_model mdl_u (.pclk, .presetn, .conv_start, .conv_abort, .lat,
      .next_value(mval), .conv_done, .conv_data);
   //////////////////////////////
   task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input string n, input logic [31:0] e, g);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
      xf(1'b0, a, 32'h0);
      chk(n, e, rdat);
   endtask
   task automatic wait_idle;
      do xf(1'b0, ACR_OFF_SC2, 32'h0); while (rdat[ACR_SC2_ACT] !== 1'b0);
   endtask
   task automatic cv(input logic [9:0] v);
      mval <= v;
      xf(1'b1, ACR_OFF_SC1, 32'h0);
      wait_idle();
   endtask
   // only whole windows are counted, so divided ticks give exact figures
   task automatic tick(input logic [7:0] c, input int lo, hi);
      int tk;
      tk = 0;
      xf(1'b1, ACR_OFF_CFG, {24'h0, c});
      repeat (16) @(negedge pclk);
      repeat (80) @(negedge pclk) tk += (conversion_clock === 1'b1);
      chk("ticks", 32'h1, {31'h0, tk >= lo && tk <= hi});
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         results();
      end
   end
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rd("sc1", ACR_OFF_SC1, 32'h1f);
      foreach (ra[i]) rd("reset", ra[i], 32'h0);
      xf(1'b0, 8'h1c, 32'h0);
      chk("slverr", 32'h1, {31'h0, rerr});
      $display("test reset done");
      xf(1'b1, ACR_OFF_SC2, 32'h0);
      mval <= 10'h3a5;
      xf(1'b1, ACR_OFF_SC1, 32'h0);
      rd("active", ACR_OFF_SC2, 32'h80);
      wait_idle();
      rd("flag", ACR_OFF_SC1, 32'h80);
      rd("high8", ACR_OFF_RH, 32'h0);
      rd("low8", ACR_OFF_RL, 32'ha5);
      rd("flagclr", ACR_OFF_SC1, 32'h0);
      xf(1'b1, ACR_OFF_SC1, 32'h0);
      xf(1'b1, ACR_OFF_SC1, 32'h1f);
      rd("abort", ACR_OFF_SC2, 32'h0);
      chk("aborts", 32'h1, n_abort);
      repeat (16) @(posedge pclk);
      rd("noflag", ACR_OFF_SC1, 32'h1f);
      rd("keep", ACR_OFF_RL, 32'ha5);
      $display("test eight bit done");
      lat <= 8'd4;
      xf(1'b1, ACR_OFF_CFG, 32'h08);
      rd("modeclr", ACR_OFF_RL, 32'h0);
      cv(10'h3a5);
      rd("high10", ACR_OFF_RH, 32'h3);
      cv(10'h155);
      rd("locked", ACR_OFF_RL, 32'ha5);
      cv(10'h155);
      rd("high10b", ACR_OFF_RH, 32'h1);
      rd("low10", ACR_OFF_RL, 32'h55);
      xf(1'b1, ACR_OFF_CFG, 32'h0);
      rd("modeclrh", ACR_OFF_RH, 32'h0);
      cv(10'h0c3);
      rd("nolock", ACR_OFF_RL, 32'hc3);
      $display("test interlock done");
      xf(1'b1, ACR_OFF_CVL, 32'h80);
      xf(1'b1, ACR_OFF_CVH, 32'h3);
      rd("cvh", ACR_OFF_CVH, 32'h3);
      xf(1'b1, ACR_OFF_SC2, 32'h20);
      cv(10'h090);
      rd("cmpnoflag", ACR_OFF_SC1, 32'h0);
      rd("cmpfalse", ACR_OFF_RL, 32'hc3);
      cv(10'h010);
      rd("cmpflag", ACR_OFF_SC1, 32'h80);
      rd("cmptrue", ACR_OFF_RL, 32'h10);
      xf(1'b1, ACR_OFF_SC2, 32'h30);
      rd("sc2", ACR_OFF_SC2, 32'h30);
      cv(10'h280);
      rd("cmpge", ACR_OFF_RL, 32'h80);
      xf(1'b1, ACR_OFF_SC2, 32'h10);
      cv(10'h005);
      rd("cmpoff", ACR_OFF_RL, 32'h05);
      xf(1'b1, ACR_OFF_RL, 32'hff);
      xf(1'b1, ACR_OFF_RH, 32'hff);
      rd("readonly", ACR_OFF_RL, 32'h05);
      mval <= 10'h066;
      xf(1'b1, ACR_OFF_SC1, 32'h20);
      repeat (30) @(posedge pclk);
      rd("contact", ACR_OFF_SC2, 32'h90);
      rd("contlow", ACR_OFF_RL, 32'h66);
      xf(1'b1, ACR_OFF_SC1, 32'h1f);
      rd("contstop", ACR_OFF_SC2, 32'h10);
      // channel back to 0 so the hardware trigger can start
      cv(10'h066);
      rd("restore", ACR_OFF_RL, 32'h66);
      $display("test compare done");
      xf(1'b1, ACR_OFF_SC2, 32'h40);
      mval <= 10'h0aa;
      @(posedge pclk) hardware_trigger_input <= 1'b1;
      repeat (3) @(posedge pclk);
      hardware_trigger_input <= 1'b0;
      wait_idle();
      rd("hwtrig", ACR_OFF_RL, 32'haa);
      $display("test trigger done");
      xf(1'b1, ACR_OFF_CFG, 32'hf0);
      rd("cfg", ACR_OFF_CFG, 32'hf0);
      chk("cfgout", 32'h6, {29'h0, conv_cfg.low_power_config,
         conv_cfg.long_sample_select, conv_cfg.mode_ten_bit});
      tick(8'h00, 80, 80);
      tick(8'h20, 40, 40);
      tick(8'h40, 20, 20);
      tick(8'h60, 10, 10);
      tick(8'h01, 40, 40);
      tick(8'h02, 27, 30);
      tick(8'h03, 17, 19);
      $display("test clock done");
      results();
   end
endmodule
bind acr_ctrl acr_ctrl_checker chk_u (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .hardware_trigger_input, .alternate_clock_input, .internal_async_clock,
   .conv_done, .conv_data, .conv_start, .conv_abort, .conversion_clock,
   .conv_cfg);
